// ### dv/ppt_pad_model.sv
`timescale 1ns/100ps

// ==========================================================
// Pad model: resolves each pin from device, outside driver and pull-up
// ==========================================================
module ppt_pad_model (
  input  wire logic                         aclk,          // Clock
  input  wire logic [ppt_pkg::PIN_BITS-1:0] pin_out,       // Device output levels
  input  wire logic [ppt_pkg::PIN_BITS-1:0] pin_oe_n,      // Device drives when low
  input  wire logic [ppt_pkg::PIN_BITS-1:0] pin_pullup_en, // Pull-up connected
  input  wire logic [ppt_pkg::PIN_BITS-1:0] pad_val,       // Outside driver levels
  input  wire logic                         pad_en,        // Outside driver active
  output logic      [ppt_pkg::PIN_BITS-1:0] pin_in         // Resolved pad levels
);
  import ppt_pkg::*;
  logic [PIN_BITS-1:0] float_q = '0;

  // A floating pad must not settle to a friendly constant, so it toggles
  always @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // Device driver wins, then the outside driver, then pull-up, else float
  assign pin_in = (~pin_oe_n & pin_out) |
                  (pin_oe_n & (pad_en ? pad_val : (pin_pullup_en | float_q)));
endmodule : ppt_pad_model

// ### dv/ppt_port_set_bench.sv
`timescale 1ns/100ps

// ==========================================================
// Self-checking bench for the port set
// ==========================================================
module ppt_port_set_bench;
  import ppt_pkg::*;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [11:0]         awaddr = '0, araddr = '0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [31:0]         wdata = '0, rdata;
  logic [3:0]          wstrb = '0;
  logic [3:0]          wstrb_v = 4'hf;
  logic [1:0]          bresp, rresp;
  logic                ext_mem_mode = 1'b0, ext_ad_oe = 1'b0, pad_en = 1'b1;
  logic [7:0]          ext_ad_out = '0, ext_addr_hi = '0;
  logic [PIN_BITS-1:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pad_val = '0;
  logic [1:0]          wq[$];
  logic [33:0]         rq[$];
  int                  n_mismatch = 0, n_tests = 0, cyc = 0;
  int                  bidir[8] = '{0, 1, 3, 4, 5, 6, 7, 9};

  always #2 aclk = ~aclk;

  ppt_port_set u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_mem_mode(ext_mem_mode), .ext_ad_out(ext_ad_out), .ext_ad_oe(ext_ad_oe),
    .ext_addr_hi(ext_addr_hi), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en));

  ppt_pad_model u_pad (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .pad_val(pad_val), .pad_en(pad_en), .pin_in(pin_in));

  // ==========================================================
  // Compare tasks and verdict
  // ==========================================================
  task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp_bus

  task automatic cmp_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp_pin

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Bus master: requests held until taken, answers taken at their edge
  // ==========================================================
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    wq.push_back(er);
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= wstrb_v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      if (awvalid && awready) ta = 1'b1;
      if (wvalid && wready) tw = 1'b1;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    rq.push_back({er, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  // Answers are checked against the oldest note, half a cycle before their handshake edge
  always @(negedge aclk) begin
    if (aresetn && bvalid && bready) cmp_bus("bresp", {32'h0, (wq.size() > 0) ? wq.pop_front() : 2'h1}, {32'h0, bresp});
    if (aresetn && rvalid && rready) cmp_bus("rdata", (rq.size() > 0) ? rq.pop_front() : 34'h1, {rresp, rdata});
  end

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [7:0] m, v, p, d, r;
    logic [11:0] b;
    int k;
    void'($urandom(32'h5bdf171f));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    // Reset state of every port: inputs, port 13 driving low
    for (k = 0; k < NPORT; k++) begin
      m = PORT_MASKS[k*8+:8];
      cmp_pin("oe_n", (k == PORT13_IDX) ? ~m : 8'hff, pin_oe_n[k*8+:8]);
      cmp_pin("out", 8'h00, pin_out[k*8+:8]);
      cmp_pin("pullup", 8'h00, pin_pullup_en[k*8+:8]);
    end
    // Each bidirectional port: latch, per-bit direction, pull-ups, read mux
    foreach (bidir[i]) begin
      k = bidir[i];
      m = PORT_MASKS[k*8+:8];
      b = 12'(k * 16);
      v = 8'($urandom);
      p = 8'($urandom);
      d = 8'($urandom);
      @(posedge aclk);
      pad_val[k*8+:8] <= p;
      axi_rd(b + 12'h4, 8'hff, RESP_OKAY);
      axi_wr(b, v, RESP_OKAY);
      axi_rd(b, p & m, RESP_OKAY);
      axi_wr(b + 12'h8, 8'hff, RESP_OKAY);
      repeat (2) @(negedge aclk);
      cmp_pin("pullup", m, pin_pullup_en[k*8+:8]);
      axi_wr(b + 12'h4, d, RESP_OKAY);
      axi_rd(b + 12'h4, d | ~m, RESP_OKAY);
      axi_rd(b, ((v & ~d) | (p & d)) & m, RESP_OKAY);
      axi_wr(b + 12'h4, 8'h00, RESP_OKAY);
      repeat (2) @(negedge aclk);
      cmp_pin("oe_n", ~m, pin_oe_n[k*8+:8]);
      cmp_pin("out", v & m, pin_out[k*8+:8]);
      cmp_pin("pullup", (k == PORT4_IDX || k == PORT5_IDX) ? m : 8'h00, pin_pullup_en[k*8+:8]);
      axi_rd(b + 12'h8, m, RESP_OKAY);
    end
    // Input-only port ignores writes and reads the pads
    p = 8'($urandom);
    @(posedge aclk);
    pad_val[PORT2_IDX*8+:8] <= p;
    axi_wr(12'h020, 8'($urandom), RESP_OKAY);
    axi_rd(12'h020, p, RESP_OKAY);
    // Output-only pin follows its latch
    axi_wr(12'h080, 8'hff, RESP_OKAY);
    repeat (2) @(negedge aclk);
    cmp_pin("out", 8'h01, pin_out[PORT13_IDX*8+:8]);
    axi_rd(12'h080, 8'h01, RESP_OKAY);
    // Low lane off: answered OKAY, latch keeps its value
    wstrb_v = 4'he;
    axi_wr(12'h080, 8'h00, RESP_OKAY);
    wstrb_v = 4'hf;
    axi_rd(12'h080, 8'h01, RESP_OKAY);
    // Unmapped places answer with an error and no data
    axi_rd(12'h024, 8'h00, RESP_SLVERR);
    axi_rd(12'h00c, 8'h00, RESP_SLVERR);
    axi_rd(12'h100, 8'h00, RESP_SLVERR);
    axi_wr(12'h0a0, 8'h5a, RESP_SLVERR);
    // Expansion mode takes over ports 4 and 5 whatever their direction
    axi_wr(12'h044, 8'hff, RESP_OKAY);
    axi_wr(12'h054, 8'hff, RESP_OKAY);
    v = 8'($urandom);
    r = 8'($urandom);
    @(posedge aclk);
    ext_mem_mode <= 1'b1;
    ext_ad_out <= v;
    ext_ad_oe <= 1'b1;
    ext_addr_hi <= r;
    repeat (3) @(negedge aclk);
    cmp_pin("out", v, pin_out[PORT4_IDX*8+:8]);
    cmp_pin("oe_n", 8'h00, pin_oe_n[PORT4_IDX*8+:8]);
    cmp_pin("out", r, pin_out[PORT5_IDX*8+:8]);
    cmp_pin("oe_n", 8'h00, pin_oe_n[PORT5_IDX*8+:8]);
    @(posedge aclk);
    ext_ad_oe <= 1'b0;
    repeat (3) @(negedge aclk);
    cmp_pin("oe_n", 8'hff, pin_oe_n[PORT4_IDX*8+:8]);
    print_verdict();
  end
endmodule : ppt_port_set_bench

// ### src/ppt_pkg.sv
package ppt_pkg;

  // ==========================================================
  // Port set shape
  // ==========================================================
  localparam int NPORT        = 10;
  localparam int PORT0_IDX    = 0;
  localparam int PORT1_IDX    = 1;
  localparam int PORT2_IDX    = 2;
  localparam int PORT3_IDX    = 3;
  localparam int PORT4_IDX    = 4;
  localparam int PORT5_IDX    = 5;
  localparam int PORT7_IDX    = 6;
  localparam int PORT12_IDX   = 7;
  localparam int PORT13_IDX   = 8;
  localparam int PORT14_IDX   = 9;
  localparam int PIN_BITS     = NPORT * 8;

  // Pins present in each port, one byte per port index, index 0 lowest
  localparam logic [PIN_BITS-1:0] PORT_MASKS = {
    8'h3f, 8'h01, 8'h01, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h7f
  };

  // Whole-device pin budget; the open-drain port is not part of this block
  localparam int PIN_TOTAL    = 67;
  localparam int CMOS_IO_PINS = 54;
  localparam int CMOS_IN_PINS = 8;
  localparam int CMOS_OUT_PINS = 1;
  localparam int OPEN_DRAIN_PINS = 4;
  localparam int PULLUP_TOTAL = 54;

  // ==========================================================
  // Register map: each port owns a 16-byte window
  // ==========================================================
  localparam int         PORT_SHIFT  = 4;
  localparam logic [1:0] SEL_DATA    = 2'h0;
  localparam logic [1:0] SEL_DIR     = 2'h1;
  localparam logic [1:0] SEL_PULL    = 2'h2;
  localparam int         MAP_BITS    = 8;

  // ==========================================================
  // Reset values and bus answers
  // ==========================================================
  localparam logic [7:0] LATCH_RST   = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'hff;
  localparam logic [7:0] OUT_DIR_RST = 8'h00;
  localparam logic [7:0] PULL_RST    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ppt_pkg

// ### src/ppt_port_set.sv
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps

// Contract
// - Port 0 has seven bidirectional pins, each with latch and own direction bit.
// - Port 0 input pins get a pull-up when their pull-up bit is set.
// - Reset puts every port 0 pin in input mode.
// - Port 1 has eight bidirectional pins with latch, direction and input pull-ups.
// - Reset puts every port 1 pin in input mode.
// - Port 2 is eight input-only pins, no latch; reads return pin levels.
// - Port 3 has four bidirectional pins with latch, direction and input pull-ups.
// - Reset puts every port 3 pin in input mode.
// - Port 4 has eight bidirectional pins; pull-ups not tied to input mode.
// - In memory expansion mode port 4 carries the multiplexed address/data bus.
// - Reset puts every port 4 pin in input mode.
// - Port 5 has eight bidirectional pins with latch, direction and pull-ups.
// - In memory expansion mode port 5 drives address lines; reset gives inputs.
// - Port 7 has eight bidirectional pins, pull-ups, inputs after reset.
// - Port 12 is one bidirectional pin with pull-up, input after reset.
// - Port 13 is one output-only pin, output after reset.
// - Port 14 has six bidirectional pins with pull-ups, inputs after reset.
// - Device pin budget is 67 pins with 54 pull-ups in all.
// - Direction bit zero turns the output buffer on, one turns it off.
// - Reset loads every direction register except port 13's with all ones.
// - Port 13 drives low after reset.
module ppt_port_set #(
  parameter int ADDR_W = 12                           // AXI address width
) (
  input  wire logic                            aclk,           // Clock, 250 MHz
  input  wire logic                            aresetn,        // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0]               awaddr,         // Write address
  input  wire logic                            awvalid,        // Write address valid
  output logic                                 awready,        // Write address ready
  input  wire logic [31:0]                     wdata,          // Write data
  input  wire logic [3:0]                      wstrb,          // Write byte strobes
  input  wire logic                            wvalid,         // Write data valid
  output logic                                 wready,         // Write data ready
  output logic [1:0]                           bresp,          // Write response
  output logic                                 bvalid,         // Write response valid
  input  wire logic                            bready,         // Write response ready
  input  wire logic [ADDR_W-1:0]               araddr,         // Read address
  input  wire logic                            arvalid,        // Read address valid
  output logic                                 arready,        // Read address ready
  output logic [31:0]                          rdata,          // Read data
  output logic [1:0]                           rresp,          // Read response
  output logic                                 rvalid,         // Read data valid
  input  wire logic                            rready,         // Read data ready
  input  wire logic                            ext_mem_mode,   // External memory expansion on
  input  wire logic [7:0]                      ext_ad_out,     // Address/data to drive on port 4
  input  wire logic                            ext_ad_oe,      // Drive port 4 in expansion mode
  input  wire logic [7:0]                      ext_addr_hi,    // Address lines for port 5
  input  wire logic [ppt_pkg::PIN_BITS-1:0]    pin_in,         // Pin levels, byte per port
  output logic [ppt_pkg::PIN_BITS-1:0]         pin_out,        // Pin output levels
  output logic [ppt_pkg::PIN_BITS-1:0]         pin_oe_n,       // Output enable, low drives
  output logic [ppt_pkg::PIN_BITS-1:0]         pin_pullup_en   // Pull-up resistor connect
);
  import ppt_pkg::*;

  // ==========================================================
  // Elaboration check
  // ==========================================================
  if (ADDR_W < MAP_BITS) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  // Pin classes must add up to the device total, or the port shapes are off
  if (CMOS_IO_PINS + CMOS_IN_PINS + CMOS_OUT_PINS + OPEN_DRAIN_PINS != PIN_TOTAL) begin : g_budget
    $error("pin budget constants do not add up");
  end

  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic [7:0] pmask(input int k);
    return PORT_MASKS[k*8 +: 8];
  endfunction : pmask

  // Ports 2 and 13 have no direction or pull-up register
  function automatic logic has_dir(input int k);
    return (k != PORT2_IDX) && (k != PORT13_IDX);
  endfunction : has_dir

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [3:0] p;
    logic [1:0] s;
    p = a[7:4];
    s = a[3:2];
    return ((a >> MAP_BITS) == '0) && (int'(p) < NPORT) &&
           ((s == SEL_DATA) || ((s <= SEL_PULL) && has_dir(int'(p))));
  endfunction : reg_hit

  // ==========================================================
  // Write channel
  // ==========================================================
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              do_wr;
  logic              wen;
  logic [3:0]        wport;
  logic [1:0]        wsel;

  assign do_wr = aw_hold_q && w_hold_q && !bvalid;
  assign wport = waddr_q[7:4];
  assign wsel  = waddr_q[3:2];
  assign wen   = do_wr && reg_hit(waddr_q) && wlane_q;

  // Address and data are taken in either order and held until both exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        waddr_q   <= awaddr;
      end else if (do_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wbyte_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
      end else if (do_wr) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Ready closes while a word waits, so only one write is ever in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awready <= !(aw_hold_q || (awvalid && awready)) && !bvalid && !do_wr;
      wready  <= !(w_hold_q || (wvalid && wready)) && !bvalid && !do_wr;
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= reg_hit(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per-port storage, pin drive and read values
  // ==========================================================
  logic [7:0] latch_q [NPORT];
  logic [7:0] dir_q   [NPORT];
  logic [7:0] pull_q  [NPORT];
  logic [7:0] rd_data [NPORT];
  logic [7:0] rd_dir  [NPORT];
  logic [7:0] rd_pull [NPORT];

  for (genvar k = 0; k < NPORT; k++) begin : g_port
    logic       wr_k;
    logic [7:0] out_d;
    logic [7:0] oen_d;
    logic [7:0] pu_d;
    logic [7:0] out_q;
    logic [7:0] oen_q;
    logic [7:0] pu_q;

    assign wr_k = wen && (wport == 4'(k));

    // Latch takes writes in any direction; port 2 has none
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        latch_q[k] <= LATCH_RST;
      end else if (wr_k && (wsel == SEL_DATA) && (k != PORT2_IDX)) begin
        latch_q[k] <= wbyte_q & pmask(k);
      end
    end

    // Direction resets to input except on port 13; absent bits read as ones
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dir_q[k] <= (k == PORT13_IDX) ? OUT_DIR_RST : DIR_RST;
      end else if (wr_k && (wsel == SEL_DIR) && has_dir(k)) begin
        dir_q[k] <= wbyte_q | ~pmask(k);
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pull_q[k] <= PULL_RST;
      end else if (wr_k && (wsel == SEL_PULL) && has_dir(k)) begin
        pull_q[k] <= wbyte_q & pmask(k);
      end
    end

    // Output pins show the latch, input pins the pad level
    assign rd_data[k] = ((latch_q[k] & ~dir_q[k]) |
                         (pin_in[k*8 +: 8] & dir_q[k])) & pmask(k);
    assign rd_dir[k]  = dir_q[k];
    assign rd_pull[k] = pull_q[k];

    // Pin drive; expansion mode hands ports 4 and 5 to the memory bus
    always_comb begin
      out_d = latch_q[k];
      oen_d = dir_q[k];
      if (ext_mem_mode && (k == PORT4_IDX)) begin
        out_d = ext_ad_out;
        oen_d = {8{!ext_ad_oe}};
      end else if (ext_mem_mode && (k == PORT5_IDX)) begin
        out_d = ext_addr_hi;
        oen_d = 8'h00;
      end
      // Ports 4 and 5 keep pull-ups whatever the direction
      if ((k == PORT4_IDX) || (k == PORT5_IDX)) begin
        pu_d = pull_q[k];
      end else begin
        pu_d = pull_q[k] & dir_q[k];
      end
    end

    // Registered so the pads never see decode glitches
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_q <= LATCH_RST;
        oen_q <= (k == PORT13_IDX) ? (OUT_DIR_RST | ~pmask(k)) : DIR_RST;
        pu_q  <= PULL_RST;
      end else begin
        out_q <= out_d & pmask(k);
        oen_q <= oen_d | ~pmask(k);
        pu_q  <= pu_d & pmask(k);
      end
    end

    assign pin_out[k*8 +: 8]       = out_q;
    assign pin_oe_n[k*8 +: 8]      = oen_q;
    assign pin_pullup_en[k*8 +: 8] = pu_q;

    // A data write reaches the latch on the next edge
    sequence data_wr_s;
      wr_k && (wsel == SEL_DATA) && (k != PORT2_IDX);
    endsequence
    latch_write_a : assert property (@(posedge aclk) disable iff (!aresetn)
      data_wr_s |=> (latch_q[k] == ($past(wbyte_q) & pmask(k))))
      else $error("latch did not take written byte");

    // Direction bit chooses the buffer state one edge later
    dir_buffer_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (!ext_mem_mode && $past(!ext_mem_mode) && $past(aresetn)) |->
        (oen_q == ($past(dir_q[k]) | ~pmask(k))))
      else $error("output enable does not follow direction");

    // A write with its low lane off leaves the latch alone
    lane_skip_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (do_wr && !wlane_q) |=> $stable(latch_q[k]))
      else $error("latch changed on a write with lane off");
  end

  // ==========================================================
  // Read channel
  // ==========================================================
  logic [3:0] rport;
  logic [1:0] rsel;
  logic [7:0] rval;

  assign rport = araddr[7:4];
  assign rsel  = araddr[3:2];

  always_comb begin
    rval = 8'h00;
    if (reg_hit(araddr)) begin
      unique case (rsel)
        SEL_DATA: rval = rd_data[rport];
        SEL_DIR:  rval = rd_dir[rport];
        default:  rval = rd_pull[rport];
      endcase
    end
  end

  // Pin levels are captured at the edge that takes the read address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rval};
      rresp   <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence reset_done_s;
    !aresetn ##1 aresetn;
  endsequence

  reset_input_a : assert property (@(posedge aclk)
    reset_done_s |-> (pin_oe_n == ~(PIN_BITS'(8'h01) << (PORT13_IDX * 8))))
    else $error("pins not in input mode after reset");

  out_low_a : assert property (@(posedge aclk)
    reset_done_s |-> (pin_out[PORT13_IDX*8] == 1'b0) && (pin_oe_n[PORT13_IDX*8] == 1'b0))
    else $error("output-only pin not driving low after reset");

  pullup_gate_a : assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (pin_pullup_en[PORT0_IDX*8 +: 8] ==
      ($past(pull_q[PORT0_IDX]) & $past(dir_q[PORT0_IDX]) & 8'h7f)))
    else $error("port 0 pull-up not gated by input mode");

  ext_ad_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_mem_mode && ext_ad_oe) |=>
      (pin_out[PORT4_IDX*8 +: 8] == $past(ext_ad_out)) && (pin_oe_n[PORT4_IDX*8 +: 8] == 8'h00))
    else $error("port 4 not carrying expansion bus");

  ext_addr_a : assert property (@(posedge aclk) disable iff (!aresetn)
    ext_mem_mode |=> (pin_oe_n[PORT5_IDX*8 +: 8] == 8'h00) &&
      (pin_out[PORT5_IDX*8 +: 8] == $past(ext_addr_hi)))
    else $error("port 5 not driving address lines");

  input_read_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && (araddr == ADDR_W'(PORT2_IDX << PORT_SHIFT))) |=>
      rvalid && (rdata[7:0] == $past(pin_in[PORT2_IDX*8 +: 8])) && (rresp == RESP_OKAY))
    else $error("input-only port read not returning pins");

  write_resp_a : assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> bvalid && !awready && !wready)
    else $error("write response missing");

endmodule : ppt_port_set
